// ==== common/tco_params.svh ====
/*
  Constants for the telecom clock output alarm selector: register offsets,
  field positions, reset values, status message codes and timing figures.
  Assumes a 100 MHz system clock and a 32-bit bus with word registers.
*/
// Summary of operation
// [RQ1] T1 SF/EXTENDED_SUPERFRAME framing kept unless ALARM_INDICATION_ALL_ONES major
// [RQ2] E1 DF/CRC framing kept unless ALARM_INDICATION_ALL_ONES major
// [RQ3] ALARM_INDICATION_ALL_ONES mode: all ones during major alarm
// [RQ4] critical alarm: every output sends all zeros
// [RQ5] unframed T1/E1 sends all ones, mode ignored
// [RQ6] no alarm: EXTENDED_SUPERFRAME 0xff20, CRC code 0010
// [RQ7] status mode major: do-not-use code sent
// [RQ8] off/ALARM_INDICATION_ALL_ONES major: framed extended keeps primary code; code keeps it in off mode only, AIS mode sends all ones
// [RQ9] plain ALTERNATE_MARK_INVERSION composite clock sends all ones
// [RQ10] violation mode inserts violation every 8 kHz
// [RQ11] marker mode adds 400 Hz non-violation frames
// [RQ12] ALARM_INDICATION_ALL_ONES major drops composite violations; off keeps
// [RQ13] faults sorted critical, major, minor by type
// [RQ14] module hardware problems raise critical alarm
// [RQ15] holdover error check only with module fitted
// [RQ16] holdover error above 1 us: major alarm
// [RQ17] threshold crossing reaches relays and status bits
// [RQ18] threshold fixed at build, not writable
// [RQ19] E1 framing: unframed, double-frame, CRC multiframe
// [RQ20] highest severity wins; minor never changes output
// [RQ21] selection changes only at frame boundary
`ifndef TCO_PARAMS_SVH
`define TCO_PARAMS_SVH

// register byte offsets
`define TCO_CFG0_OFS     8'h00
`define TCO_CFG1_OFS     8'h04
`define TCO_STATUS_OFS   8'h08
`define TCO_FAULT_OFS    8'h0c
`define TCO_SEL0_OFS     8'h10
`define TCO_SEL1_OFS     8'h14

// field positions and reset values
`define TCO_CFG_W        8
`define TCO_CFG_RESET    8'h00
`define TCO_STAT_ALM_LSB 0
`define TCO_STAT_MIN_BIT 2
`define TCO_STAT_HLD_BIT 3
`define TCO_STAT_FIT_BIT 4
`define TCO_FAULT_W      12
`define TCO_SEL_W        21

// status message codes
`define TCO_SSM_T1_PRC   16'hff20
`define TCO_SSM_T1_DNU   16'hff0c
`define TCO_SSM_E1_PRC   16'h0002
`define TCO_SSM_E1_DNU   16'h000f

// timing
`define TCO_CLK_NS       10
`define TCO_FRAME_NS     125000
`define TCO_MARK_NS      2500000
`define TCO_HOLD_ERR_NS  32'h0000_03e8

`endif

// ==== common/tco_pkg.sv ====
/*
  Types for the telecom clock output alarm selector.
  Assumes tco_params.svh supplies all numeric constants.
*/
package tco_pkg;

  typedef enum logic [1:0] {KIND_T1 = 2'h0, KIND_E1 = 2'h1, KIND_CC = 2'h2} out_kind_e;
  typedef enum logic [1:0] {FRM_UNFRAMED = 2'h0, FRM_BASIC = 2'h1, FRM_EXTENDED = 2'h2} framing_e;
  typedef enum logic [1:0] {AMODE_OFF = 2'h0, AMODE_AIS = 2'h1, AMODE_SSM = 2'h2} alarm_mode_e;
  typedef enum logic [1:0] {LC_AMI = 2'h0, LC_BPV = 2'h1, LC_BPV_MARK = 2'h2} line_code_e;
  // gray order along none -> major -> critical
  typedef enum logic [1:0] {ALM_NONE = 2'h0, ALM_MAJOR = 2'h1, ALM_CRITICAL = 2'h3} alarm_e;

  typedef enum logic [3:0] {
    LINE_ONES         = 4'h0,
    LINE_ZEROS        = 4'h1,
    LINE_SF           = 4'h2,
    LINE_ESF          = 4'h3,
    LINE_DF           = 4'h4,
    LINE_CRC          = 4'h5,
    LINE_AMI          = 4'h6,
    LINE_AMI_BPV      = 4'h7,
    LINE_AMI_BPV_MARK = 4'h8
  } line_e;

  typedef struct packed {
    out_kind_e   kind;
    framing_e    framing;
    alarm_mode_e amode;
    line_code_e  lcode;
  } cfg_s;

  typedef struct packed {
    line_e       line;
    logic        ssm_valid;
    logic [15:0] ssm_code;
  } sel_s;

  typedef struct packed {
    logic hw_cpu;
    logic hw_telecom;
    logic power_b;
    logic power_a;
    logic antenna;
    logic no_polling;
    logic time_input;
    logic rx_comm;
    logic flash_write;
    logic config_load;
    logic no_signal;
    logic cv_range;
  } fault_s;

endpackage

// ==== logic/frame_timer.sv ====
/*
  Frame boundary timer: one-cycle tick per 125 us frame and a marker tick
  on every frame that starts a 400 Hz period.
  Assumes the system clock and its clock enable.
*/
module frame_timer
  import tco_pkg::*;
#(
  parameter int FRAME_CYCLES = 12500,
  parameter int MARK_FRAMES  = 20
) (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  // ticks
  output logic      frame_tick,
  output logic      mark_tick
);

  logic [15:0] cyc_cnt;
  logic [7:0]  frm_cnt;

  // cycle counter inside a frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc_cnt <= 16'h0000;
    end else if (ce) begin
      if (cyc_cnt == 16'(FRAME_CYCLES - 1)) begin
        cyc_cnt <= 16'h0000;
      end else begin
        cyc_cnt <= cyc_cnt + 16'h0001;
      end
    end
  end

  // frame counter inside a marker period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frm_cnt <= 8'h00;
    end else if (ce && cyc_cnt == 16'(FRAME_CYCLES - 1)) begin
      if (frm_cnt == 8'(MARK_FRAMES - 1)) begin
        frm_cnt <= 8'h00;
      end else begin
        frm_cnt <= frm_cnt + 8'h01;
      end
    end
  end

  // registered ticks, one cycle wide
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_tick <= 1'b0;
      mark_tick  <= 1'b0;
    end else if (ce) begin
      frame_tick <= (cyc_cnt == 16'(FRAME_CYCLES - 1));
      mark_tick  <= (cyc_cnt == 16'(FRAME_CYCLES - 1)) && (frm_cnt == 8'(MARK_FRAMES - 1));
    end
  end

endmodule

// ==== logic/telecom_clock_output_alarm_select.sv ====
/*
  Telecom clock output alarm selector: sorts faults into alarm severity,
  checks the holdover time error, and picks the line signal and status
  message for two telecom outputs at frame boundaries. AHB-Lite register
  slave for configuration and status.
  Assumes fault pins are asynchronous, time error comes from logic on hclk,
  and ce stays high while a bus transfer is in progress.
*/
`include "tco_params.svh"

module telecom_clock_output_alarm_select
  import tco_pkg::*;
#(
  parameter int FRAME_CYCLES = `TCO_FRAME_NS / `TCO_CLK_NS
) (
  // clock, reset, enable
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              ce,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // fault pins and module presence
  input  wire logic [11:0]       fault_pins,
  input  wire logic              module_fitted,
  // holdover time error from the discipline loop
  input  wire logic              in_holdover,
  input  wire logic [31:0]       time_error_ns,
  // alarm relays
  output logic                   relay_minor,
  output logic                   relay_major,
  output logic                   relay_critical,
  // per-output line selection
  output sel_s      [1:0]        chan_sel,
  output logic      [1:0]        bpv_pulse,
  output logic      [1:0]        marker_pulse
);

  localparam int MARK_FRAMES = `TCO_MARK_NS / `TCO_FRAME_NS;

  // every property here lives on hclk and sleeps through reset
  default clocking dflt_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // line selection for one output under one alarm state
  function automatic sel_s pick_line(cfg_s c, alarm_e a);
    sel_s s;
    logic ais_major;
    s = '{line: LINE_ONES, ssm_valid: 1'b0, ssm_code: 16'h0000};
    ais_major = (a == ALM_MAJOR) && (c.amode == AMODE_AIS);
    if (a == ALM_CRITICAL) begin
      s.line = LINE_ZEROS; // RQ4
    end else if (c.kind == KIND_CC) begin
      case (c.lcode)
        LC_BPV:      s.line = ais_major ? LINE_AMI : LINE_AMI_BPV;      // RQ10 RQ12
        LC_BPV_MARK: s.line = ais_major ? LINE_AMI : LINE_AMI_BPV_MARK; // RQ11 RQ12
        default:     s.line = LINE_AMI;                                 // RQ9
      endcase
    end else begin
      case (c.framing)
        FRM_BASIC: begin
          if (ais_major) begin
            s.line = LINE_ONES; // RQ3
          end else begin
            s.line = (c.kind == KIND_E1) ? LINE_DF : LINE_SF; // RQ1 RQ2
          end
        end
        FRM_EXTENDED: begin
          if (ais_major) begin
            s.line = LINE_ONES; // RQ3
          end else begin
            s.line      = (c.kind == KIND_E1) ? LINE_CRC : LINE_ESF; // RQ1 RQ2
            s.ssm_valid = 1'b1;
            if (a == ALM_MAJOR && c.amode == AMODE_SSM) begin
              s.ssm_code = (c.kind == KIND_E1) ? `TCO_SSM_E1_DNU : `TCO_SSM_T1_DNU; // RQ7
            end else begin
              s.ssm_code = (c.kind == KIND_E1) ? `TCO_SSM_E1_PRC : `TCO_SSM_T1_PRC; // RQ6 RQ8
            end
          end
        end
        default: s.line = LINE_ONES; // RQ5 RQ19
      endcase
    end
    return s;
  endfunction

  fault_s      fault_sync;
  logic [12:0] sync_a;
  logic [12:0] sync_b;
  logic        fitted;
  logic        hold_err;
  logic        crit_any;
  logic        major_any;
  logic        minor_any;
  alarm_e      alarm_q;
  cfg_s  [1:0] cfg;
  logic        frame_tick;
  logic        mark_tick;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic [7:0]  rd_addr;
  logic        addr_ok;
  logic [31:0] next_rdata;

  // two-stage synchronisers for fault pins and module presence
  genvar gi;
  generate
    for (gi = 0; gi < 13; gi++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else if (ce) begin
          sync_a[gi] <= (gi == 12) ? module_fitted : fault_pins[gi % 12];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  assign fault_sync = fault_s'(sync_b[11:0]);
  assign fitted     = sync_b[12];

  // threshold is a build constant with no register behind it
  assign hold_err  = fitted && in_holdover && (time_error_ns > `TCO_HOLD_ERR_NS); // RQ15 RQ16 RQ18
  assign crit_any  = fault_sync.config_load || fault_sync.flash_write || fault_sync.rx_comm
                   || fault_sync.hw_telecom || fault_sync.hw_cpu; // RQ13 RQ14
  assign major_any = fault_sync.no_signal || fault_sync.time_input || fault_sync.no_polling
                   || hold_err; // RQ13 RQ16
  assign minor_any = fault_sync.cv_range || fault_sync.antenna || fault_sync.power_a
                   || fault_sync.power_b; // RQ13

  // severity priority; minor faults only reach their relay and status bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_q <= ALM_NONE;
    end else if (ce) begin
      if (crit_any) begin
        alarm_q <= ALM_CRITICAL; // RQ20
      end else if (major_any) begin
        alarm_q <= ALM_MAJOR; // RQ20
      end else begin
        alarm_q <= ALM_NONE;
      end
    end
  end

  // relays follow faults at once, not at a frame edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      relay_minor    <= 1'b0;
      relay_major    <= 1'b0;
      relay_critical <= 1'b0;
    end else if (ce) begin
      relay_minor    <= minor_any;
      relay_major    <= major_any && !crit_any; // RQ17
      relay_critical <= crit_any;
    end
  end

  frame_timer #(
    .FRAME_CYCLES (FRAME_CYCLES),
    .MARK_FRAMES  (MARK_FRAMES)
  ) u_timer (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .ce         (ce),
    .frame_tick (frame_tick),
    .mark_tick  (mark_tick)
  );

  // per-output selection and violation strobes
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      // swap only on a frame edge so no frame is cut short
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          chan_sel[gi] <= '{line: LINE_ONES, ssm_valid: 1'b0, ssm_code: 16'h0000};
        end else if (ce && frame_tick) begin
          chan_sel[gi] <= pick_line(cfg[gi], alarm_q); // RQ21 RQ17
        end
      end

      // violation each frame; marker frames carry none
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          bpv_pulse[gi]    <= 1'b0;
          marker_pulse[gi] <= 1'b0;
        end else if (ce) begin
          bpv_pulse[gi]    <= frame_tick && ((chan_sel[gi].line == LINE_AMI_BPV)
                              || (chan_sel[gi].line == LINE_AMI_BPV_MARK && !mark_tick)); // RQ10
          marker_pulse[gi] <= frame_tick && mark_tick && (chan_sel[gi].line == LINE_AMI_BPV_MARK); // RQ11
        end
      end

      crit_zero_a: assert property (ce && frame_tick && alarm_q == ALM_CRITICAL // RQ4
                                    |=> chan_sel[gi].line == LINE_ZEROS)
        else $error("critical alarm did not force all zeros");

      frame_hold_a: assert property (!(ce && frame_tick) |=> $stable(chan_sel[gi])) // RQ21
        else $error("selection changed off a frame boundary");

      ais_ones_a: assert property (ce && frame_tick && alarm_q == ALM_MAJOR && cfg[gi].kind != KIND_CC // RQ3
                                   && cfg[gi].amode == AMODE_AIS
                                   |=> chan_sel[gi].line == LINE_ONES && !chan_sel[gi].ssm_valid)
        else $error("alarm indication did not send all ones");

      ssm_dnu_a: assert property (ce && frame_tick && alarm_q == ALM_MAJOR && cfg[gi].kind == KIND_T1 // RQ7
                                  && cfg[gi].framing == FRM_EXTENDED && cfg[gi].amode == AMODE_SSM
                                  |=> chan_sel[gi].ssm_code == `TCO_SSM_T1_DNU)
        else $error("do-not-use code missing in status mode");

      unframed_a: assert property (ce && frame_tick && alarm_q != ALM_CRITICAL && cfg[gi].kind != KIND_CC // RQ5
                                   && cfg[gi].framing == FRM_UNFRAMED
                                   |=> chan_sel[gi].line == LINE_ONES)
        else $error("unframed output not all ones");

      bpv_strobe_a: assert property (ce && frame_tick && chan_sel[gi].line == LINE_AMI_BPV // RQ10
                                     |=> bpv_pulse[gi])
        else $error("violation strobe missing");
    end
  endgenerate

  hold_major_a: assert property (ce && hold_err && !crit_any // RQ16 RQ17
                                 |=> alarm_q == ALM_MAJOR && relay_major)
    else $error("holdover error did not raise major alarm");

  // alarm_q follows the fault seen at the edge before it
  crit_wins_a: assert property (ce && crit_any |=> alarm_q == ALM_CRITICAL) // RQ20
    else $error("critical fault lost to lower severity");

  // without the module no time error may reach the alarm
  fitted_only_a: assert property (ce && !fitted && !crit_any && !fault_sync.no_signal // RQ15
                                  && !fault_sync.time_input && !fault_sync.no_polling
                                  |=> alarm_q == ALM_NONE)
    else $error("holdover check active without module");

  crit_seen_c: cover property (ce && frame_tick && alarm_q == ALM_CRITICAL);
  dnu_sent_c: cover property (chan_sel[1].ssm_code == `TCO_SSM_T1_DNU);
  marker_c: cover property (|marker_pulse);
  hold_err_c: cover property (hold_err ##1 relay_major);

  // bus: address phase capture; writes land in the data phase
  assign addr_ok = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else if (ce) begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  // configuration registers; unmapped writes are dropped
  generate
    for (gi = 0; gi < 2; gi++) begin : g_cfg
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cfg[gi] <= cfg_s'(`TCO_CFG_RESET);
        end else if (ce && wr_pend && wr_addr == (gi == 0 ? `TCO_CFG0_OFS : `TCO_CFG1_OFS)) begin
          cfg[gi] <= cfg_s'(hwdata[`TCO_CFG_W-1:0]);
        end
      end
    end
  endgenerate

  // read mux; a write still in its data phase is forwarded
  assign rd_addr = haddr[7:0];
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (rd_addr)
      `TCO_CFG0_OFS: next_rdata[`TCO_CFG_W-1:0] = (wr_pend && wr_addr == rd_addr) ?
                                                  hwdata[`TCO_CFG_W-1:0] : cfg[0];
      `TCO_CFG1_OFS: next_rdata[`TCO_CFG_W-1:0] = (wr_pend && wr_addr == rd_addr) ?
                                                  hwdata[`TCO_CFG_W-1:0] : cfg[1];
      `TCO_STATUS_OFS: begin
        next_rdata[`TCO_STAT_ALM_LSB +: 2] = alarm_q;
        next_rdata[`TCO_STAT_MIN_BIT]      = minor_any;
        next_rdata[`TCO_STAT_HLD_BIT]      = hold_err;
        next_rdata[`TCO_STAT_FIT_BIT]      = fitted;
      end
      `TCO_FAULT_OFS: next_rdata[`TCO_FAULT_W-1:0] = fault_sync;
      `TCO_SEL0_OFS:  next_rdata[`TCO_SEL_W-1:0]   = chan_sel[0];
      `TCO_SEL1_OFS:  next_rdata[`TCO_SEL_W-1:0]   = chan_sel[1];
      default:        next_rdata = 32'h0000_0000;
    endcase
  end

  // zero-wait slave, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_ok && !hwrite) begin
        hrdata <= next_rdata;
      end
    end
  end

endmodule

// ==== dv/clock_input_model.sv ====
/*
  Far-side clock input model: tallies violation and marker pulses per output
  and counts selection changes that land away from a frame edge.
  Assumes chan_sel moves only one enabled edge after an internal frame tick.
*/
module clock_input_model
  import tco_pkg::*;
#(
  parameter int FRAME_CYCLES = 20
) (
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              ce,
  // line selection from the device
  input  wire sel_s  [1:0]       chan_sel,
  input  wire logic  [1:0]       bpv_pulse,
  input  wire logic  [1:0]       marker_pulse,
  // tally window
  input  wire logic              clr,
  output logic       [1:0][15:0] bpv_cnt,
  output logic       [1:0][15:0] mark_cnt,
  output logic       [15:0]      off_edge
);
  timeunit 1ns;
  timeprecision 1ps;
  int          cyc;
  sel_s  [1:0] last;

  // frame position counts enabled edges only, like the device timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cyc      <= 0;
      off_edge <= '0;
      last     <= '0;
    end else begin
      if (chan_sel != last && cyc % FRAME_CYCLES != 1) off_edge <= off_edge + 16'h1;
      last <= chan_sel;
      if (ce) cyc <= cyc + 1;
    end
  end

  // a frozen pulse is counted once, on the enabled edge only
  always_ff @(posedge hclk) begin
    for (int i = 0; i < 2; i++) begin
      if (clr) begin
        bpv_cnt[i]  <= '0;
        mark_cnt[i] <= '0;
      end else if (ce) begin
        bpv_cnt[i]  <= bpv_cnt[i] + 16'(bpv_pulse[i]);
        mark_cnt[i] <= mark_cnt[i] + 16'(marker_pulse[i]);
      end
    end
  end
endmodule

// ==== dv/telecom_clock_output_alarm_select_tb.sv ====
/*
  Testbench of the telecom clock output alarm selector: register bus tasks,
  fault and holdover stimulus, expected selection from the alarm tables.
  Assumes a 20-cycle frame and the zero-wait-state slave of the hand-over.
*/
`include "tco_params.svh"

module telecom_clock_output_alarm_select_tb
  import tco_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FC = 20;
  logic              hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp, clr;
  logic              module_fitted, in_holdover, relay_minor, relay_major, relay_critical;
  logic [1:0]        htrans, bpv_pulse, marker_pulse;
  logic [2:0]        hsize;
  logic [11:0]       fault_pins;
  logic [15:0]       off_edge;
  logic [31:0]       haddr, hwdata, hrdata, time_error_ns, rnd, rd;
  logic [1:0][15:0]  bpv_cnt, mark_cnt;
  sel_s [1:0]        chan_sel;
  int                error_cnt, checks_done;

  assign hready = hreadyout;

  telecom_clock_output_alarm_select #(.FRAME_CYCLES(FC)) i_telecom_clock_output_alarm_select (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .fault_pins(fault_pins), .module_fitted(module_fitted),
    .in_holdover(in_holdover), .time_error_ns(time_error_ns), .relay_minor(relay_minor),
    .relay_major(relay_major), .relay_critical(relay_critical), .chan_sel(chan_sel),
    .bpv_pulse(bpv_pulse), .marker_pulse(marker_pulse));

  clock_input_model #(.FRAME_CYCLES(FC)) i_clock_input_model (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .chan_sel(chan_sel), .bpv_pulse(bpv_pulse),
    .marker_pulse(marker_pulse), .clr(clr), .bpv_cnt(bpv_cnt), .mark_cnt(mark_cnt), .off_edge(off_edge));

  // free-running system clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic alarm_e exp_alm(input logic [11:0] f, input logic herr);
    if (|(f & 12'hc1c)) return ALM_CRITICAL;
    if (|(f & 12'h062) || herr) return ALM_MAJOR;
    return ALM_NONE;
  endfunction

  // line, status flag and code as the alarm tables give them
  function automatic logic [20:0] exp_sel(input cfg_s c, input alarm_e a);
    line_e       l;
    logic        v, alarm_indication_all_ones, dnu;
    logic [15:0] code;
    alarm_indication_all_ones  = (a == ALM_MAJOR) && (c.amode == AMODE_AIS);
    dnu  = (a == ALM_MAJOR) && (c.amode == AMODE_SSM);
    v    = 1'b0;
    code = 16'h0;
    l    = LINE_ONES;
    if (a == ALM_CRITICAL) l = LINE_ZEROS;
    else if (c.kind == KIND_CC) l = (c.lcode == LC_AMI || alarm_indication_all_ones) ? LINE_AMI :
                                    (c.lcode == LC_BPV) ? LINE_AMI_BPV : LINE_AMI_BPV_MARK;
    else if (!alarm_indication_all_ones && c.framing inside {FRM_BASIC, FRM_EXTENDED}) begin
      if (c.kind == KIND_T1) l = (c.framing == FRM_BASIC) ? LINE_SF : LINE_ESF;
      else l = (c.framing == FRM_BASIC) ? LINE_DF : LINE_CRC;
      v = (c.framing == FRM_EXTENDED);
      if (c.kind == KIND_T1) code = dnu ? `TCO_SSM_T1_DNU : `TCO_SSM_T1_PRC;
      else code = dnu ? `TCO_SSM_E1_DNU : `TCO_SSM_E1_PRC;
      if (!v) code = 16'h0;
    end
    return {l, v, code};
  endfunction

  // the code field means nothing while its flag is low
  function automatic logic [20:0] nrm(input logic [20:0] s);
    return s[16] ? s : {s[20:17], 17'h0};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one single transfer; both phases wait on hready with a bound
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    int n;
    n = 0;
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
    r = hrdata;
    check({31'h0, hresp}, 32'h0);
    if (n >= 100) check(32'h0, 32'h1);
  endtask

  task automatic run_case(input logic [11:0] f, input logic [7:0] c0, c1, input logic ho, fit,
                          input logic [31:0] te);
    logic   herr;
    alarm_e a;
    bus(1'b1, `TCO_CFG0_OFS, {24'h0, c0}, rd);
    bus(1'b1, `TCO_CFG1_OFS, {24'h0, c1}, rd);
    fault_pins    <= f;
    in_holdover   <= ho;
    module_fitted <= fit;
    time_error_ns <= te;
    ce            <= 1'b0;
    cyc(3);
    ce <= 1'b1;
    cyc(2 * FC + 8);
    herr = fit & ho & (te > 32'h3e8);
    a    = exp_alm(f, herr);
    check({relay_critical, relay_major, relay_minor}, {a == ALM_CRITICAL, a == ALM_MAJOR, |(f & 12'h381)});
    check(nrm(chan_sel[0]), exp_sel(cfg_s'(c0), a));
    check(nrm(chan_sel[1]), exp_sel(cfg_s'(c1), a));
    bus(1'b0, `TCO_STATUS_OFS, 32'h0, rd);
    check(rd, {27'h0, fit, herr, |(f & 12'h381), a});
    bus(1'b0, `TCO_FAULT_OFS, 32'h0, rd);
    check(rd, {20'h0, f});
    bus(1'b0, `TCO_SEL0_OFS, 32'h0, rd);
    check(nrm(rd[20:0]), exp_sel(cfg_s'(c0), a));
  endtask

  task automatic pulse_win(input logic [15:0] b1, b0, m1, m0);
    clr <= 1'b1;
    cyc(1);
    clr <= 1'b0;
    cyc(40 * FC + 1);
    check({bpv_cnt[1], bpv_cnt[0]}, {b1, b0});
    check({mark_cnt[1], mark_cnt[0]}, {m1, m0});
  endtask

  function automatic logic [7:0] rcfg(input logic [31:0] r);
    return {2'(r[7:0] % 3), r[9:8], 2'(r[15:10] % 3), 2'(r[21:16] % 3)};
  endfunction

  // hang guard, well beyond the planned run
  initial begin
    #400000;
    error_cnt++;
    give_verdict();
  end

  // main sequence
  initial begin
    hresetn = 1'b0; ce = 1'b1; hsel = 1'b0; htrans = 2'h0; haddr = '0; hwrite = 1'b0; hsize = 3'h2;
    hwdata = '0; fault_pins = '0; module_fitted = 1'b0; in_holdover = 1'b0; time_error_ns = '0;
    clr = 1'b0; error_cnt = 0; checks_done = 0; rnd = 32'h0001_2dbd;
    cyc(2);
    hresetn <= 1'b1;
    bus(1'b0, `TCO_CFG0_OFS, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b0, `TCO_SEL0_OFS, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b1, 8'h20, 32'hffff_ffff, rd);
    bus(1'b0, 8'h20, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b1, `TCO_STATUS_OFS, 32'hffff_ffff, rd);
    bus(1'b0, `TCO_STATUS_OFS, 32'h0, rd);
    check(rd, 32'h0);
    bus(1'b1, `TCO_CFG1_OFS, 32'h0000_0066, rd);
    bus(1'b0, `TCO_CFG1_OFS, 32'h0, rd);
    check(rd, 32'h0000_0066);
    $display("test registers done");
    // each fault type alone, under random settings
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      run_case(12'h1 << i, rcfg(rnd), rcfg(lfsr(rnd)), 1'b0, 1'b0, 32'h0);
    end
    $display("test fault types done");
    run_case(12'h0, 8'h62, 8'h22, 1'b1, 1'b1, 32'h3e8);
    time_error_ns <= 32'h3e9;
    cyc(2);
    check(relay_major, 1'b1);
    run_case(12'h0, 8'h6a, 8'h2a, 1'b1, 1'b1, 32'h3e9);
    run_case(12'h0, 8'h6a, 8'h2a, 1'b1, 1'b0, 32'h1388);
    run_case(12'h0, 8'h6a, 8'h2a, 1'b0, 1'b1, 32'h1388);
    $display("test holdover done");
    run_case(12'h0, 8'h81, 8'h86, 1'b0, 1'b0, 32'h0);
    pulse_win(16'd38, 16'd40, 16'd2, 16'd0);
    run_case(12'h002, 8'h81, 8'h86, 1'b0, 1'b0, 32'h0);
    pulse_win(16'd0, 16'd40, 16'd0, 16'd0);
    $display("test composite clock done");
    for (int i = 0; i < 30; i++) begin
      rnd = lfsr(lfsr(rnd));
      run_case(rnd[11:0] & rnd[23:12] & rnd[31:20], rcfg(rnd), rcfg(lfsr(rnd)), rnd[24], rnd[25],
               32'h3e3 + 32'(rnd[29:26]));
    end
    check(off_edge, 32'h0);
    $display("test random done");
    give_verdict();
  end
endmodule
